// [common/bmc_pkg.sv]
// Constants, register layout and state encoding for the external bus mode controller.
package bmc_pkg;

    // Register offsets on the APB (byte addresses).
    localparam int          PADDR_W  = 12;
    localparam logic [11:0] OFS_MODE = 12'h000;
    localparam logic [11:0] OFS_CTRL = 12'h004;
    localparam logic [11:0] OFS_STAT = 12'h008;

    // Bus mode register layout and reset value.
    localparam logic [7:0] MODE_RESET      = 8'hd3;
    localparam int         MODE_IDLE_INSERT_SELECT_BIT   = 6;
    localparam int         MODE_BROM_BIT   = 5;
    localparam int         MODE_BSTATE_BIT = 4;
    localparam int         MODE_BLEN_BIT   = 3;
    localparam int         MODE_IOSR_HI    = 1;
    localparam int         MODE_IOSR_LO    = 0;

    // Control register layout and reset value.
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam int         CTRL_MUX_BIT  = 0;
    localparam int         CTRL_IO_STROBE_ENABLE_BIT = 1;
    localparam int         CTRL_A256_BIT = 2;
    localparam int         CTRL_CP_BIT   = 3;

    // External area bounds.
    localparam logic [23:0] A256_BASE     = 24'hf80000;
    localparam logic [23:0] A256_LAST     = 24'hfbffff;
    localparam logic [23:0] A256_MUX_LAST = 24'hf8ffff;
    localparam logic [23:0] CP_BASE       = 24'hffc000;
    localparam logic [23:0] CP_LAST       = 24'hffdfff;
    localparam logic [23:0] IOS_BASE      = 24'hfff000;

    // Offset of the last I/O strobe byte for each range code.
    localparam logic [10:0] IOS_SPAN_0 = 11'h07f;
    localparam logic [10:0] IOS_SPAN_1 = 11'h0ff;
    localparam logic [10:0] IOS_SPAN_2 = 11'h3ff;
    localparam logic [10:0] IOS_SPAN_3 = 11'h7ff;

    // State counts of the bus cycles and word limits of a burst.
    localparam logic [3:0] IDLE_STATES     = 4'h1;
    localparam logic [3:0] BASIC_STATES    = 4'h2;
    localparam logic [3:0] BURST_SHORT     = 4'h1;
    localparam logic [3:0] BURST_LONG      = 4'h2;
    localparam logic [3:0] BURST_MAX_SHORT = 4'h4;
    localparam logic [3:0] BURST_MAX_LONG  = 4'h8;

    typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_FIRST, ST_BURST} bmc_state_e;

endpackage

// [core/bmc_area_decode.sv]
// Address decoder for the 256-kbyte, CP and I/O strobe areas.
`timescale 1ns/1ps
`default_nettype none
module bmc_area_decode
    import bmc_pkg::*;
(
    input  wire logic [23:0] addr,
    input  wire logic        mux_mode,
    input  wire logic        io_strobe_enable,
    input  wire logic        a256_en,
    input  wire logic        cp_en,
    input  wire logic [1:0]  ios_range,
    output logic             in_ios,
    output logic             in_a256,
    output logic             in_cp,
    output logic             burst_excl
);
    logic [10:0] span;

    // Range code to span; the encoding is held as package constants.
    always_comb begin
        unique case (ios_range)
            2'b00:   span = IOS_SPAN_0;
            2'b01:   span = IOS_SPAN_1;
            2'b10:   span = IOS_SPAN_2;
            2'b11:   span = IOS_SPAN_3;
        endcase
    end

    // The 256-kbyte area shrinks to 64 kbytes in multiplex mode.
    assign in_a256 = addr >= A256_BASE && addr <= (mux_mode ? A256_MUX_LAST : A256_LAST);
    assign in_cp   = addr >= CP_BASE && addr <= CP_LAST;
    assign in_ios  = io_strobe_enable && addr[23:11] == IOS_BASE[23:11] && addr[10:0] <= span;
    // Enabled 256-kbyte and CP areas never run burst timing.
    assign burst_excl = (a256_en && in_a256) || (cp_en && in_cp);
endmodule
`default_nettype wire

// [core/bmc_state_timer.sv]
// Down counter that marks the last state of a bus phase.
`timescale 1ns/1ps
`default_nettype none
module bmc_state_timer #(
    parameter int W = 4
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              last
);
    logic [W-1:0] cnt_r;

    generate
        if (W < 2) begin : g_bad
            $error("bmc_state_timer needs at least two bits");
        end
    endgenerate

    // Loaded with the state count on entry, counts down to zero and holds; last marks a count of one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= load_val;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign last = cnt_r == W'(1);
endmodule
`default_nettype wire

// [core/bmc_ctrl.sv]
// External bus mode controller: APB registers and external cycle sequencer.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Optional single idle state between read and write.
// - Mode bit picks basic or burst interface.
// - Enabled 256k and CP areas never burst.
// - Burst cycle lasts one or two states.
// - Burst limited to four or eight words.
// - Burst controls ignored in multiplex mode.
// - Two low bits select I/O strobe range.
// - Control bit selects normal or multiplex mode.
// - I/O strobe asserted inside enabled strobe area.
module bmc_ctrl
    import bmc_pkg::*;
#(
    parameter int DATA_W  = 16,
    parameter int WORDS_W = 4
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               req_valid,
    output logic                    req_ready,
    input  wire logic               req_write,
    input  wire logic [23:0]        req_addr,
    input  wire logic [DATA_W-1:0]  req_wdata,
    input  wire logic [WORDS_W-1:0] req_words,
    output logic                    rsp_valid,
    output logic                    rsp_last,
    output logic [DATA_W-1:0]       rsp_rdata,
    output logic [23:0]             ext_addr,
    output logic [DATA_W-1:0]       ext_dout,
    output logic                    ext_dout_oe,
    input  wire logic [DATA_W-1:0]  ext_din,
    output logic                    ext_rd_n,
    output logic                    ext_wr_n,
    output logic                    ext_ios_n,
    output logic                    ext_cs256_n,
    output logic                    ext_cpcs_n,
    output logic                    ext_mux_mode,
    output logic                    ext_idle
);
    logic [7:0]         mode_r;
    logic [7:0]         ctrl_r;
    logic [31:0]        prdata_r;
    logic               pslverr_r;
    bmc_state_e         state_r;
    bmc_state_e         state_nxt;
    logic [WORDS_W-1:0] words_left_r;
    logic [WORDS_W-1:0] max_words_r;
    logic               cur_write_r;
    logic               cur_mux_r;
    logic               bstate_r;
    logic               cs_ios_r;
    logic               cs_a256_r;
    logic               cs_cp_r;
    logic [23:0]        ext_addr_r;
    logic [DATA_W-1:0]  ext_dout_r;
    logic               rsp_valid_r;
    logic               rsp_last_r;
    logic [DATA_W-1:0]  rsp_rdata_r;
    logic               in_ios;
    logic               in_a256;
    logic               in_cp;
    logic               burst_excl;
    logic               tmr_last;
    logic               tmr_load;
    logic [3:0]         tmr_val;
    logic               accept;
    logic               active;
    logic               word_done;
    logic               last_cycle;
    logic               need_gap;
    logic               burst_ok;
    logic [WORDS_W-1:0] words_req;
    logic [WORDS_W-1:0] words_cap;
    logic [WORDS_W-1:0] words_new;
    logic               apb_setup;
    logic               apb_wr;
    logic [7:0]         stat_w;

    generate
        if (DATA_W != 8 && DATA_W != 16) begin : g_bad_data
            $error("bmc_ctrl supports 8 or 16 bit external data");
        end
        if (WORDS_W < 4) begin : g_bad_words
            $error("bmc_ctrl needs a word count of at least four bits");
        end
    endgenerate

    // APB: zero-wait slave; read data and error are captured in the setup cycle.
    assign apb_setup = psel && !penable;
    assign apb_wr    = psel && penable && pwrite;
    assign pready    = 1'b1;
    assign prdata    = prdata_r;
    assign pslverr   = pslverr_r;
    assign stat_w    = {words_left_r[3:0], cur_mux_r, state_r == ST_BURST, state_r == ST_GAP, active};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (apb_setup) begin
            pslverr_r <= !(paddr == OFS_MODE || paddr == OFS_CTRL || paddr == OFS_STAT);
            unique case (paddr)
                OFS_MODE: prdata_r <= {24'h000000, mode_r};
                OFS_CTRL: prdata_r <= {24'h000000, ctrl_r};
                OFS_STAT: prdata_r <= {24'h000000, stat_w};
                default:  prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // Register writes; reserved mode bits are stored as written and kept by software, control bits 7:4 are stored as zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= MODE_RESET;
            ctrl_r <= CTRL_RESET;
        end else if (apb_wr) begin
            if (paddr == OFS_MODE) begin
                mode_r <= pwdata[7:0];
            end
            if (paddr == OFS_CTRL) begin
                ctrl_r <= {4'h0, pwdata[3:0]};
            end
        end
    end

    bmc_area_decode u_decode (
        .addr       (req_addr),
        .mux_mode   (ctrl_r[CTRL_MUX_BIT]),
        .io_strobe_enable       (ctrl_r[CTRL_IO_STROBE_ENABLE_BIT]),
        .a256_en    (ctrl_r[CTRL_A256_BIT]),
        .cp_en      (ctrl_r[CTRL_CP_BIT]),
        .ios_range  (mode_r[MODE_IOSR_HI:MODE_IOSR_LO]),
        .in_ios     (in_ios),
        .in_a256    (in_a256),
        .in_cp      (in_cp),
        .burst_excl (burst_excl)
    );

    bmc_state_timer #(.W(4)) u_timer (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (tmr_load),
        .load_val (tmr_val),
        .last     (tmr_last)
    );

    // Sequencing terms; a new request may be taken in the last state of the final word of a transfer.
    assign active     = state_r == ST_FIRST || state_r == ST_BURST;
    assign word_done  = active && tmr_last;
    assign last_cycle = word_done && words_left_r == WORDS_W'(1);
    assign req_ready  = state_r == ST_IDLE || last_cycle;
    assign accept     = req_valid && req_ready;
    assign need_gap   = last_cycle && !cur_write_r && req_write && mode_r[MODE_IDLE_INSERT_SELECT_BIT];

    // Burst only for reads in normal mode with burst ROM selected.
    assign burst_ok  = mode_r[MODE_BROM_BIT] && !ctrl_r[CTRL_MUX_BIT] && !burst_excl && !req_write;
    assign words_cap = mode_r[MODE_BLEN_BIT] ? WORDS_W'(BURST_MAX_LONG) : WORDS_W'(BURST_MAX_SHORT);
    assign words_req = (req_words == '0) ? WORDS_W'(1) : req_words;
    assign words_new = !burst_ok ? WORDS_W'(1) : (words_req > words_cap ? words_cap : words_req);

    // Next state and timer load.
    always_comb begin
        state_nxt = state_r;
        tmr_load  = 1'b0;
        tmr_val   = BASIC_STATES;
        if (accept) begin
            state_nxt = need_gap ? ST_GAP : ST_FIRST;
            tmr_load  = 1'b1;
            tmr_val   = need_gap ? IDLE_STATES : BASIC_STATES;
        end else if (state_r == ST_GAP && tmr_last) begin
            state_nxt = ST_FIRST;
            tmr_load  = 1'b1;
        end else if (last_cycle) begin
            state_nxt = ST_IDLE;
        end else if (word_done) begin
            state_nxt = ST_BURST;
            tmr_load  = 1'b1;
            tmr_val   = bstate_r ? BURST_LONG : BURST_SHORT;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Per-transfer attributes latched when the request is taken.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_write_r <= 1'b0;
            cur_mux_r   <= 1'b0;
            bstate_r    <= 1'b0;
            max_words_r <= WORDS_W'(1);
            cs_ios_r    <= 1'b0;
            cs_a256_r   <= 1'b0;
            cs_cp_r     <= 1'b0;
        end else if (accept) begin
            cur_write_r <= req_write;
            cur_mux_r   <= ctrl_r[CTRL_MUX_BIT];
            bstate_r    <= mode_r[MODE_BSTATE_BIT];
            max_words_r <= words_cap;
            cs_ios_r    <= in_ios;
            cs_a256_r   <= in_a256 && ctrl_r[CTRL_A256_BIT];
            cs_cp_r     <= in_cp && ctrl_r[CTRL_CP_BIT];
        end
    end

    // Word count and address; burst words step by the bus width.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            words_left_r <= '0;
            ext_addr_r   <= 24'h000000;
            ext_dout_r   <= '0;
        end else if (accept) begin
            words_left_r <= words_new;
            ext_addr_r   <= req_addr;
            ext_dout_r   <= req_wdata;
        end else if (word_done && !last_cycle) begin
            words_left_r <= words_left_r - WORDS_W'(1);
            ext_addr_r   <= ext_addr_r + 24'(DATA_W / 8);
        end else if (last_cycle) begin
            words_left_r <= '0;
        end
    end

    // Read data handed back once per completed word.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_valid_r <= 1'b0;
            rsp_last_r  <= 1'b0;
            rsp_rdata_r <= '0;
        end else begin
            rsp_valid_r <= word_done;
            rsp_last_r  <= last_cycle;
            if (word_done && !cur_write_r) begin
                rsp_rdata_r <= ext_din;
            end
        end
    end

    // External strobes follow the sequencer state.
    assign rsp_valid    = rsp_valid_r;
    assign rsp_last     = rsp_last_r;
    assign rsp_rdata    = rsp_rdata_r;
    assign ext_addr     = ext_addr_r;
    assign ext_dout     = ext_dout_r;
    assign ext_dout_oe  = state_r == ST_FIRST && cur_write_r;
    assign ext_rd_n     = !(active && !cur_write_r);
    assign ext_wr_n     = !(state_r == ST_FIRST && cur_write_r);
    assign ext_ios_n    = !(active && cs_ios_r);
    assign ext_cs256_n  = !(active && cs_a256_r);
    assign ext_cpcs_n   = !(active && cs_cp_r);
    assign ext_mux_mode = ctrl_r[CTRL_MUX_BIT];
    assign ext_idle     = state_r == ST_GAP;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_gap_inserted: assert property (accept && need_gap |=> state_r == ST_GAP ##1 state_r == ST_FIRST)
        else $error("idle state missing between read and write");
    a_gap_skipped: assert property (last_cycle && accept && !mode_r[MODE_IDLE_INSERT_SELECT_BIT] |=> state_r == ST_FIRST)
        else $error("idle state inserted while disabled");
    a_basic_single: assert property (accept && !mode_r[MODE_BROM_BIT] |=> words_left_r == WORDS_W'(1))
        else $error("basic interface ran a burst");
    a_area_no_burst: assert property (accept && burst_excl |=> words_left_r == WORDS_W'(1))
        else $error("burst timing applied to special area");
    a_burst_one_state: assert property (state_r == ST_BURST && $changed(state_r) && !bstate_r |-> tmr_last)
        else $error("short burst cycle longer than one state");
    a_burst_two_state: assert property (state_r == ST_BURST && $changed(state_r) && bstate_r |-> !tmr_last ##1 tmr_last)
        else $error("long burst cycle not two states");
    a_burst_word_max: assert property (active |-> words_left_r <= max_words_r)
        else $error("burst exceeds word limit");
    a_mux_no_burst: assert property (state_r == ST_BURST |-> !cur_mux_r)
        else $error("burst in multiplex mode");
    a_ios_strobe_area: assert property (accept && in_ios |-> ##[1:2] !ext_ios_n)
        else $error("strobe missing in strobe area");
    a_ios_needs_enable: assert property (accept && !ctrl_r[CTRL_IO_STROBE_ENABLE_BIT] |=> !cs_ios_r)
        else $error("strobe without enable");

    c_gap_path: cover property (accept && need_gap ##2 state_r == ST_FIRST);
    c_burst_eight: cover property (accept && words_new == WORDS_W'(8));
    c_ios_access: cover property (!ext_ios_n);
    c_apb_error: cover property (psel && penable && pslverr);
endmodule
`default_nettype wire

// [tb/bmc_ext_mem.sv]
// Behavioural external memory that answers the bus mode controller's cycles.
`timescale 1ns/1ps
`default_nettype none
module bmc_ext_mem (
    input  wire logic        pclk,
    input  wire logic [23:0] ext_addr,
    input  wire logic [15:0] ext_dout,
    input  wire logic        ext_dout_oe,
    input  wire logic        ext_rd_n,
    input  wire logic        ext_wr_n,
    output logic [15:0]      ext_din,
    output logic [15:0]      wdat
);
    logic [15:0] last_r;

    // A read word follows the address; off the strobe the bus shows the inverse of the last word.
    always_comb begin
        if (ext_rd_n == 1'b0) begin
            ext_din = ext_addr[15:0] ^ 16'h3c00;
        end else begin
            ext_din = ~last_r;
        end
    end

    // Remembers the last driven word and the last written word.
    always_ff @(posedge pclk) begin
        last_r <= ext_din;
        if (ext_wr_n == 1'b0 && ext_dout_oe == 1'b1) begin
            wdat <= ext_dout;
        end
    end
endmodule
`default_nettype wire

// [tb/bmc_ctrl_tb_top.sv]
// Self-checking testbench of the bus mode controller.
`timescale 1ns/1ps
`default_nettype none
module bmc_ctrl_tb_top;
    import bmc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, req_valid = 1'b0, req_ready, req_write = 1'b0;
    logic [23:0] req_addr = 24'h0, ext_addr;
    logic [15:0] req_wdata = 16'h0, rsp_rdata, ext_dout, ext_din, wdat, rdat;
    logic [3:0] req_words = 4'h1;
    logic rsp_valid, rsp_last, ext_dout_oe, ext_rd_n, ext_wr_n;
    logic ext_ios_n, ext_cs256_n, ext_cpcs_n, ext_mux_mode, ext_idle;
    logic [31:0] ard;
    logic aerr;
    logic [2:0] sel;
    int n_fail = 0, tests_run = 0, cyc = 0, words, idles, lat, gap;

    bmc_ctrl i_bmc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_words(req_words), .rsp_valid(rsp_valid), .rsp_last(rsp_last),
        .rsp_rdata(rsp_rdata), .ext_addr(ext_addr), .ext_dout(ext_dout), .ext_dout_oe(ext_dout_oe),
        .ext_din(ext_din), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_ios_n(ext_ios_n),
        .ext_cs256_n(ext_cs256_n), .ext_cpcs_n(ext_cpcs_n), .ext_mux_mode(ext_mux_mode), .ext_idle(ext_idle));
    bmc_ext_mem i_bmc_ext_mem (.pclk(pclk), .ext_addr(ext_addr), .ext_dout(ext_dout), .ext_dout_oe(ext_dout_oe),
        .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_din(ext_din), .wdat(wdat));

    // Clock of 25 ns period and a cycle counter that cuts a hang short.
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            complete_run();
        end
    end

    // Counts one comparison and reports a mismatch.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; read data and error are taken at the completing edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        ard = prdata;
        aerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Writes the mode register with the reserved bits kept at their reset levels.
    task automatic mode(input logic [3:0] b, input logic [1:0] io_strobe_chip_select);
        apb(1'b1, OFS_MODE, {24'h0, 1'b1, b, 1'b0, io_strobe_chip_select});
    endtask

    // Runs one external request, or a read followed at once by a write, and records what is seen.
    task automatic run(input logic w, input logic [23:0] a, input logic [3:0] n, input bit pair);
        int t;
        int lastw;
        int lasts;
        bit pend;
        t = 0;
        lastw = 0;
        lasts = 0;
        pend = pair;
        words = 0;
        idles = 0;
        lat = 0;
        sel = 3'h0;
        @(posedge pclk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_words <= n;
        req_wdata <= a[15:0] ^ 16'h0f0f;
        do @(posedge pclk); while (req_ready !== 1'b1);
        if (pair) begin
            req_write <= 1'b1;
        end else begin
            req_valid <= 1'b0;
        end
        while (lasts < (pair ? 2 : 1) && t < 80) begin
            @(negedge pclk);
            t++;
            if (rsp_valid === 1'b1) begin
                words++;
                if (lat == 0) lat = t;
                gap = t - lastw;
                lastw = t;
                rdat = rsp_rdata;
            end
            if (rsp_last === 1'b1) lasts++;
            if (ext_idle === 1'b1) idles++;
            sel |= {ext_cpcs_n === 1'b0, ext_cs256_n === 1'b0, ext_ios_n === 1'b0};
            @(posedge pclk);
            if (pend && req_ready === 1'b1) begin
                pend = 1'b0;
                req_valid <= 1'b0;
            end
        end
    endtask

    // Reset values, readback and an unmapped address.
    task automatic t_regs();
        apb(1'b0, OFS_MODE, 32'h0);
        chk("mode reset", 32'h000000d3, ard);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h00000000, ard);
        mode(4'h5, 2'h2);
        apb(1'b0, OFS_MODE, 32'h0);
        chk("mode readback", 32'h000000aa, ard);
        apb(1'b1, 12'h00c, 32'h000000ff);
        chk("unmapped write err", 32'h1, {31'h0, aerr});
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped read", 32'h1, {31'h0, aerr});
        chk("unmapped data", 32'h0, ard);
    endtask

    // Basic interface: single word, fixed latency, data from the memory.
    task automatic t_basic();
        mode(4'h0, 2'h3);
        run(1'b0, 24'h001234, 4'hf, 1'b0);
        chk("basic words", 32'd1, words);
        chk("basic latency", 32'd3, lat);
        chk("basic data", {16'h0, 16'h1234 ^ 16'h3c00}, {16'h0, rdat});
    endtask

    // Read then write back to back, with and without the idle state.
    task automatic t_idle();
        for (int i = 0; i < 2; i++) begin
            mode({i[0], 3'h0}, 2'h3);
            run(1'b0, 24'h000100 + 24'(2 * i), 4'h1, 1'b1);
            chk("idle states", i, idles);
            chk("write data", {16'h0, (16'h0100 + 16'(2 * i)) ^ 16'h0f0f}, {16'h0, wdat});
        end
    endtask

    // Every burst state and length setting, plus a short request.
    task automatic t_burst();
        for (int k = 0; k < 4; k++) begin
            mode({2'b01, k[0], k[1]}, 2'h3);
            run(1'b0, 24'h000200, 4'hf, 1'b0);
            chk("burst words", k[1] ? 8 : 4, words);
            chk("burst gap", k[0] ? 2 : 1, gap);
            chk("burst last data", {16'h0, (16'h0200 + 16'(2 * (words - 1))) ^ 16'h3c00}, {16'h0, rdat});
        end
        run(1'b0, 24'h000200, 4'h2, 1'b0);
        chk("short burst", 32'd2, words);
    endtask

    // Multiplex mode ignores the burst controls.
    task automatic t_mux();
        mode(4'h7, 2'h3);
        apb(1'b1, OFS_CTRL, 32'h1);
        run(1'b0, 24'h000200, 4'hf, 1'b0);
        chk("mux mode out", 32'h1, {31'h0, ext_mux_mode});
        chk("mux words", 32'd1, words);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("mux latched", 32'h8, ard);
        apb(1'b1, OFS_CTRL, 32'h0);
        @(negedge pclk);
        chk("normal mode out", 32'h0, {31'h0, ext_mux_mode});
    endtask

    // Enabled 256-kbyte and CP areas never burst.
    task automatic t_area();
        mode(4'h7, 2'h3);
        apb(1'b1, OFS_CTRL, 32'h4);
        run(1'b0, A256_BASE + 24'h10, 4'hf, 1'b0);
        chk("a256 words", 32'd1, words);
        chk("a256 select", 32'h2, {29'h0, sel});
        apb(1'b1, OFS_CTRL, 32'h8);
        run(1'b0, CP_BASE + 24'h10, 4'hf, 1'b0);
        chk("cp words", 32'd1, words);
        chk("cp select", 32'h4, {29'h0, sel});
    endtask

    // Strobe stays off when disabled; each range code ends at its last byte.
    task automatic t_ios();
        logic [10:0] span [4];
        span = '{IOS_SPAN_0, IOS_SPAN_1, IOS_SPAN_2, IOS_SPAN_3};
        apb(1'b1, OFS_CTRL, 32'h0);
        run(1'b0, IOS_BASE, 4'h1, 1'b0);
        chk("ios disabled", 32'h0, {31'h0, sel[0]});
        apb(1'b1, OFS_CTRL, 32'h2);
        for (int c = 0; c < 4; c++) begin
            mode(4'h0, c[1:0]);
            run(1'b0, IOS_BASE + {13'h0, span[c]}, 4'h1, 1'b0);
            chk("ios inside", 32'h1, {31'h0, sel[0]});
            run(1'b0, IOS_BASE + {13'h0, span[c]} + 24'h1, 4'h1, 1'b0);
            chk("ios outside", 32'h0, {31'h0, sel[0]});
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_basic();
        t_idle();
        t_burst();
        t_mux();
        t_area();
        t_ios();
        complete_run();
    end
endmodule
`default_nettype wire
